// File: sim/spi_data_buffer_irq_regs_test.sv
// Self-checking bench for the serial port register bank
`timescale 1ns/1ps
`include "spi_regs_consts.svh"
module spi_data_buffer_irq_regs_test;
    logic clk_sys;
    logic rst_n;
    logic [5:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
    logic [15:0] rdata_ff;
    logic irq_ff;
    logic sclk_pin;
    logic mosi_pin;
    logic miso_ff;
    logic miso_oe_n_ff;
    logic [7:0] got;
    int failures;
    int num_checks;

    spi_data_buffer_irq_regs spi_data_buffer_irq_regs_i (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .addr(addr),
        .wdata(wdata),
        .wr(wr),
        .rd(rd),
        .rdata_ff(rdata_ff),
        .irq_ff(irq_ff),
        .sclk_pin(sclk_pin),
        .mosi_pin(mosi_pin),
        .miso_ff(miso_ff),
        .miso_oe_n_ff(miso_oe_n_ff)
    );

    spi_master_model spi_master_model_i (
        .sclk(sclk_pin),
        .mosi(mosi_pin),
        .miso(miso_ff),
        .miso_oe_n(miso_oe_n_ff)
    );

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report();
        if (failures == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // A gap cycle between calls keeps each strobe to one assignment per step
    task automatic wr_reg(input logic [5:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask

    task automatic rd_chk(input string what, input logic [5:0] a, input logic [15:0] exp);
        @(posedge clk_sys);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1;
        check(what, rdata_ff, exp);
    endtask

    task automatic frame(input logic [7:0] tx, input int nbits, input logic [15:0] exp);
        spi_master_model_i.xfer(tx, nbits, got);
        check("miso char", {8'h00, got}, exp);
        repeat (10) @(posedge clk_sys);
    endtask

    task automatic irq_chk(input logic exp);
        #1;
        check("irq", {15'h0000, irq_ff}, {15'h0000, exp});
    endtask

    initial begin
        rst_n = 1'b0;
        addr = 6'h00;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
        failures = 0;
        num_checks = 0;
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        irq_chk(1'b0);
        rd_chk("tx reset", `OFF_TX_DATA, 16'h0000);
        rd_chk("ie reset", `OFF_IRQ_ENABLE, 16'h0000);
        rd_chk("flags reset", `OFF_IRQ_FLAGS, 16'h0002);
        rd_chk("iv reset", `OFF_IRQ_VECTOR, `VEC_NONE);
        rd_chk("unmapped", 6'h3E, 16'h0000);
        wr_reg(`OFF_IRQ_ENABLE, 16'hFFFF);
        rd_chk("ie rw", `OFF_IRQ_ENABLE, 16'h0003);
        rd_chk("iv tx", `OFF_IRQ_VECTOR, `VEC_TX);
        irq_chk(1'b1);
        wr_reg(`OFF_IRQ_ENABLE, 16'h0001);
        rd_chk("iv masked", `OFF_IRQ_VECTOR, `VEC_NONE);
        irq_chk(1'b0);
        // Written while the port is held, so nothing can take it yet
        wr_reg(`OFF_TX_DATA, 16'hFFA5);
        rd_chk("tx hold", `OFF_TX_DATA, 16'h00A5);
        rd_chk("flags tx written", `OFF_IRQ_FLAGS, 16'h0000);
        wr_reg(`OFF_CONTROL, 16'h0000);
        repeat (4) @(posedge clk_sys);
        rd_chk("flags tx taken", `OFF_IRQ_FLAGS, 16'h0002);
        check("miso oe", {15'h0000, miso_oe_n_ff}, 16'h0000);
        frame(8'h3C, 8, 16'h00A5);
        rd_chk("flags rx", `OFF_IRQ_FLAGS, 16'h0003);
        irq_chk(1'b1);
        wr_reg(`OFF_IRQ_ENABLE, 16'h0003);
        rd_chk("iv rx first", `OFF_IRQ_VECTOR, `VEC_RX);
        rd_chk("rx data", `OFF_RX_DATA, 16'h003C);
        rd_chk("flags rx read", `OFF_IRQ_FLAGS, 16'h0002);
        rd_chk("iv after read", `OFF_IRQ_VECTOR, `VEC_TX);
        // Two characters with no read between them
        wr_reg(`OFF_TX_DATA, 16'h0011);
        repeat (4) @(posedge clk_sys);
        frame(8'h55, 8, 16'h0011);
        wr_reg(`OFF_TX_DATA, 16'h0022);
        repeat (4) @(posedge clk_sys);
        frame(8'h66, 8, 16'h0022);
        rd_chk("overrun set", `OFF_STATUS, 16'h0020);
        rd_chk("rx last", `OFF_RX_DATA, 16'h0066);
        rd_chk("overrun cleared", `OFF_STATUS, 16'h0000);
        rd_chk("rx flag cleared", `OFF_IRQ_FLAGS, 16'h0002);
        // Length may change only while the port is held
        wr_reg(`OFF_CONTROL, 16'h1001);
        wr_reg(`OFF_TX_DATA, 16'h00FF);
        rd_chk("tx seven", `OFF_TX_DATA, 16'h007F);
        wr_reg(`OFF_CONTROL, 16'h1000);
        repeat (4) @(posedge clk_sys);
        frame(8'hD5, 7, 16'h007F);
        rd_chk("rx seven", `OFF_RX_DATA, 16'h0055);
        wr_reg(`OFF_IRQ_FLAGS, 16'h0000);
        rd_chk("iv none", `OFF_IRQ_VECTOR, `VEC_NONE);
        irq_chk(1'b0);
        final_report();
    end

    initial begin
        #300000;
        failures++;
        final_report();
    end
endmodule

// File: sim/spi_master_model.sv
// Behavioural link master driving clock and data into the slave port
`timescale 1ns/1ps
module spi_master_model (
    output logic sclk,
    output logic mosi,
    input wire logic miso,
    input wire logic miso_oe_n
);
    initial begin
        sclk = 1'b0;
        mosi = 1'b0;
    end

    // Mode 0, MSB first; the clock stands low between frames
    task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = nbits - 1; i >= 0; i--) begin
            mosi = tx[i];
            #200;
            sclk = 1'b1;
            rx[i] = miso_oe_n ? 1'b0 : miso;
            #200;
            sclk = 1'b0;
        end
        // Released data line shows the inverse, not a stale value
        mosi = ~mosi;
    endtask
endmodule

// File: verilog/link_if.sv
// Internal carrier between shift engine and register bank
`timescale 1ns/1ps
interface link_if;
    logic [7:0] tx_byte;
    logic tx_take;
    logic tx_full;
    logic [7:0] rx_byte;
    logic rx_load;
    logic seven_bit;
    modport bank (output tx_byte, output tx_full, output seven_bit, input tx_take, input rx_byte, input rx_load);
    modport engine (input tx_byte, input tx_full, input seven_bit, output tx_take, output rx_byte, output rx_load);
endinterface

// File: verilog/pin_sync.sv
// Two flip-flop synchroniser for one pin
`timescale 1ns/1ps
module pin_sync (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic pin_in,
    output logic pin_out
);
    logic meta_ff;
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            meta_ff <= 1'b0;
            pin_out <= 1'b0;
        end else begin
            meta_ff <= pin_in;
            pin_out <= meta_ff;
        end
    end
endmodule

// File: verilog/shift_engine.sv
// Slave shift engine: samples the link clock and moves characters
`timescale 1ns/1ps
module shift_engine
    import spi_regs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic sclk_s,
    input wire logic mosi_s,
    input wire logic enable,
    output logic miso_ff,
    link_if.engine lk
);
    shift_state_t state_ff;
    logic sclk_d_ff;
    logic [7:0] sh_rx_ff;
    logic [7:0] sh_tx_ff;
    logic [3:0] cnt_ff;
    logic [3:0] len;
    logic rise;
    logic fall;
    assign len = lk.seven_bit ? 4'd7 : 4'd8;
    assign rise = sclk_s & ~sclk_d_ff;
    assign fall = ~sclk_s & sclk_d_ff;
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sclk_d_ff <= 1'b0;
        end else begin
            sclk_d_ff <= sclk_s;
        end
    end
    // Mode 0, MSB first; only the shift path, not the full option set
    always_ff @(posedge clk_sys) begin
        if (!rst_n || !enable) begin
            state_ff <= SH_IDLE;
            cnt_ff <= 4'd0;
            sh_rx_ff <= 8'h00;
            sh_tx_ff <= 8'h00;
            miso_ff <= 1'b0;
            lk.tx_take <= 1'b0;
            lk.rx_load <= 1'b0;
            lk.rx_byte <= 8'h00;
        end else begin
            lk.tx_take <= 1'b0;
            lk.rx_load <= 1'b0;
            case (state_ff)
                SH_IDLE: begin
                    if (lk.tx_full) begin
                        // Seven-bit mode ignores bit 7
                        sh_tx_ff <= lk.seven_bit ? {lk.tx_byte[6:0], 1'b0} : lk.tx_byte;
                        miso_ff <= lk.seven_bit ? lk.tx_byte[6] : lk.tx_byte[7];
                        lk.tx_take <= 1'b1;
                        cnt_ff <= 4'd0;
                        state_ff <= SH_SHIFT;
                    end
                end
                SH_SHIFT: begin
                    if (rise) begin
                        sh_rx_ff <= {sh_rx_ff[6:0], mosi_s};
                        cnt_ff <= cnt_ff + 4'd1;
                        if (cnt_ff + 4'd1 == len) begin
                            state_ff <= SH_DONE;
                        end
                    end else if (fall) begin
                        sh_tx_ff <= {sh_tx_ff[6:0], 1'b0};
                        miso_ff <= sh_tx_ff[6];
                    end
                end
                default: begin
                    lk.rx_byte <= lk.seven_bit ? {1'b0, sh_rx_ff[6:0]} : sh_rx_ff;
                    lk.rx_load <= 1'b1;
                    state_ff <= SH_IDLE;
                end
            endcase
        end
    end
endmodule

// File: verilog/spi_data_buffer_irq_regs.sv
// Data buffer and interrupt registers of a slave serial port
// Behaviour
// - Receive register shows last character, upper zero
// - Reading receive data clears errors and flag
// - Seven-bit receive is right-aligned, bit7 zero
// - Transmit register holds byte, resets zero
// - Writing transmit data clears empty flag; an engine take in the same cycle leaves it set
// - Seven-bit mode ignores and zeroes transmit bit7
// - Transmit-empty flag bit1, resets to one
// - Receive-done flag bit0 set on character
// - Enable register: tx bit1, rx bit0
// - Vector 0x000 idle, 0x002 receive first
// - Vector 0x004 for transmit when no receive
// - Overrun set when unread character replaced
// - Length control one selects seven bits
`timescale 1ns/1ps
`include "spi_regs_consts.svh"
module spi_data_buffer_irq_regs
    import spi_regs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [5:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata_ff,
    output logic irq_ff,
    input wire logic sclk_pin,
    input wire logic mosi_pin,
    output logic miso_ff,
    output logic miso_oe_n_ff
);
    link_if lk ();
    logic sclk_s;
    logic mosi_s;
    logic seven_bit_select_ff;
    logic port_enable_ff;
    logic [7:0] rx_char_field_ff;
    logic [7:0] tx_char_field_ff;
    logic tx_full_ff;
    logic [1:0] irq_enable_ff;
    logic tx_empty_flag_ff;
    logic rx_done_flag_ff;
    logic overrun_flag_ff;
    logic [15:0] vector_value;
    logic [15:0] nxt_rdata;
    logic wr_tx;
    logic rd_rx;
    logic rd_iv;
    logic [7:0] tx_mask;
    logic wr_ctl;
    logic wr_ie;
    logic wr_ifg;
    logic unread_ff;

    pin_sync u_sclk (.clk_sys(clk_sys), .rst_n(rst_n), .pin_in(sclk_pin), .pin_out(sclk_s));
    pin_sync u_mosi (.clk_sys(clk_sys), .rst_n(rst_n), .pin_in(mosi_pin), .pin_out(mosi_s));

    shift_engine u_eng (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .sclk_s(sclk_s),
        .mosi_s(mosi_s),
        .enable(port_enable_ff),
        .miso_ff(miso_ff),
        .lk(lk)
    );

    assign wr_tx = wr && (addr == `OFF_TX_DATA);
    assign rd_rx = rd && (addr == `OFF_RX_DATA);
    assign rd_iv = rd && (addr == `OFF_IRQ_VECTOR);
    assign wr_ctl = wr && (addr == `OFF_CONTROL);
    assign wr_ie = wr && (addr == `OFF_IRQ_ENABLE);
    assign wr_ifg = wr && (addr == `OFF_IRQ_FLAGS);
    assign tx_mask = seven_bit_select_ff ? 8'h7F : 8'hFF;
    assign lk.tx_byte = tx_char_field_ff;
    assign lk.tx_full = tx_full_ff;
    assign lk.seven_bit = seven_bit_select_ff;

    // Control word: length select and an enable for the shift engine
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            seven_bit_select_ff <= 1'b0;
            port_enable_ff <= 1'b0;
        end else if (wr && addr == `OFF_CONTROL) begin
            seven_bit_select_ff <= wdata[`BIT_SEVEN_BIT];
            port_enable_ff <= ~wdata[0];
        end
    end

    // Pin driven only while the port runs
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            miso_oe_n_ff <= 1'b1;
        end else begin
            miso_oe_n_ff <= ~port_enable_ff;
        end
    end

    // Receive buffer; a stale bit 7 is dropped once seven-bit mode is on
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rx_char_field_ff <= 8'h00;
        end else if (lk.rx_load) begin
            rx_char_field_ff <= lk.rx_byte;
        end else if (seven_bit_select_ff) begin
            rx_char_field_ff[7] <= 1'b0;
        end
    end

    // Transmit buffer; bit 7 forced low in seven-bit mode
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            tx_char_field_ff <= `RST_TX_DATA;
        end else if (wr_tx) begin
            tx_char_field_ff <= wdata[7:0] & tx_mask;
        end else if (seven_bit_select_ff) begin
            tx_char_field_ff[7] <= 1'b0;
        end
    end

    // Buffer full until the engine takes it; a write wins over a take
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            tx_full_ff <= 1'b0;
        end else if (wr_tx) begin
            tx_full_ff <= 1'b1;
        end else if (lk.tx_take) begin
            tx_full_ff <= 1'b0;
        end
    end

    // Transmit-empty flag: hardware set wins over software clear
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            tx_empty_flag_ff <= 1'(`RST_IRQ_FLAGS >> `BIT_TX_EMPTY);
        end else if (lk.tx_take) begin
            tx_empty_flag_ff <= 1'b1;
        end else if (wr_tx) begin
            tx_empty_flag_ff <= 1'b0;
        end else if (wr && addr == `OFF_IRQ_FLAGS) begin
            tx_empty_flag_ff <= wdata[`BIT_TX_EMPTY];
        end
    end

    // Receive-done flag: a new character beats the read clear
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rx_done_flag_ff <= 1'(`RST_IRQ_FLAGS >> `BIT_RX_DONE);
        end else if (lk.rx_load) begin
            rx_done_flag_ff <= 1'b1;
        end else if (rd_rx) begin
            rx_done_flag_ff <= 1'b0;
        end else if (wr && addr == `OFF_IRQ_FLAGS) begin
            rx_done_flag_ff <= wdata[`BIT_RX_DONE];
        end
    end

    // Own unread marker, so a flags write cannot hide an overrun
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            unread_ff <= 1'b0;
        end else if (lk.rx_load) begin
            unread_ff <= 1'b1;
        end else if (rd_rx) begin
            unread_ff <= 1'b0;
        end
    end

    // Overrun: only a receive read clears it
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            overrun_flag_ff <= 1'b0;
        end else if (lk.rx_load && unread_ff && !rd_rx) begin
            overrun_flag_ff <= 1'b1;
        end else if (rd_rx) begin
            overrun_flag_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            irq_enable_ff <= `RST_IRQ_ENABLE;
        end else if (wr && addr == `OFF_IRQ_ENABLE) begin
            irq_enable_ff <= wdata[1:0];
        end
    end

    // Receive outranks transmit
    always_comb begin
        if (rx_done_flag_ff && irq_enable_ff[`BIT_RX_DONE]) begin
            vector_value = `VEC_RX;
        end else if (tx_empty_flag_ff && irq_enable_ff[`BIT_TX_EMPTY]) begin
            vector_value = `VEC_TX;
        end else begin
            vector_value = `VEC_NONE;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |({tx_empty_flag_ff, rx_done_flag_ff} & irq_enable_ff);
        end
    end

    // Read decode; unmapped addresses read zero
    always_comb begin
        if (addr == `OFF_CONTROL) begin
            nxt_rdata = {3'b000, seven_bit_select_ff, 11'h000, ~port_enable_ff};
        end else if (addr == `OFF_STATUS) begin
            nxt_rdata = {10'h000, overrun_flag_ff, 5'h00};
        end else if (addr == `OFF_RX_DATA) begin
            nxt_rdata = {8'h00, rx_char_field_ff};
        end else if (addr == `OFF_TX_DATA) begin
            nxt_rdata = {8'h00, tx_char_field_ff};
        end else if (addr == `OFF_IRQ_ENABLE) begin
            nxt_rdata = {14'h0000, irq_enable_ff};
        end else if (addr == `OFF_IRQ_FLAGS) begin
            nxt_rdata = {14'h0000, tx_empty_flag_ff, rx_done_flag_ff};
        end else if (addr == `OFF_IRQ_VECTOR) begin
            nxt_rdata = vector_value;
        end else begin
            nxt_rdata = 16'h0000;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rdata_ff <= 16'h0000;
        end else if (rd) begin
            rdata_ff <= nxt_rdata;
        end else begin
            rdata_ff <= 16'h0000;
        end
    end

    // Clear and set paths, vector choice and request level
    chk_rx_read_clears: assert property (@(posedge clk_sys) disable iff (!rst_n)
        rd_rx && !lk.rx_load |=> !rx_done_flag_ff && !overrun_flag_ff)
        else $error("receive read did not clear flags");
    chk_tx_write_clears: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr_tx && !lk.tx_take |=> !tx_empty_flag_ff)
        else $error("transmit write left empty flag");
    chk_rx_sets_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
        lk.rx_load |=> rx_done_flag_ff && rx_char_field_ff == $past(lk.rx_byte))
        else $error("receive load lost");
    chk_seven_rx: assert property (@(posedge clk_sys) disable iff (!rst_n)
        seven_bit_select_ff && lk.rx_load |=> !rx_char_field_ff[7])
        else $error("seven-bit receive bit7 set");
    chk_seven_tx: assert property (@(posedge clk_sys) disable iff (!rst_n)
        seven_bit_select_ff ##1 seven_bit_select_ff |-> !tx_char_field_ff[7])
        else $error("seven-bit transmit bit7 set");
    chk_overrun_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
        lk.rx_load && unread_ff && !rd_rx |=> overrun_flag_ff)
        else $error("overrun missed");
    chk_vector_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
        rd_iv && rx_done_flag_ff && irq_enable_ff[0] |=> rdata_ff == 16'h0002)
        else $error("vector not receive");
    chk_vector_tx: assert property (@(posedge clk_sys) disable iff (!rst_n)
        rd_iv && !(rx_done_flag_ff && irq_enable_ff[0]) && tx_empty_flag_ff && irq_enable_ff[1]
        |=> rdata_ff == 16'h0004)
        else $error("vector not transmit");
    chk_irq_level: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ##1 irq_ff == $past(|({tx_empty_flag_ff, rx_done_flag_ff} & irq_enable_ff)))
        else $error("interrupt level wrong");
    chk_take_sets_empty: assert property (@(posedge clk_sys) disable iff (!rst_n)
        lk.tx_take |=> tx_empty_flag_ff && tx_full_ff == $past(wr_tx))
        else $error("take did not set empty");

    // Receive side
    chk_rx_read_data: assert property (@(posedge clk_sys) disable iff (!rst_n)
        rd_rx |=> rdata_ff == {8'h00, $past(rx_char_field_ff)})
        else $error("receive read data wrong");
    chk_rx_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !lk.rx_load && !seven_bit_select_ff |=> $stable(rx_char_field_ff))
        else $error("receive buffer changed");
    chk_seven_rx_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
        seven_bit_select_ff ##1 (seven_bit_select_ff && rd_rx) |=> !rdata_ff[7])
        else $error("seven-bit receive read bit7 set");
    chk_rx_flag_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        rx_done_flag_ff && !rd_rx && !wr_ifg |=> rx_done_flag_ff)
        else $error("receive flag dropped");
    chk_rx_no_spurious: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !lk.rx_load && !rx_done_flag_ff && !wr_ifg |=> !rx_done_flag_ff)
        else $error("receive flag set without character");
    chk_overrun_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        overrun_flag_ff && !rd_rx |=> overrun_flag_ff)
        else $error("overrun dropped");
    chk_overrun_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
        rd_rx |=> !overrun_flag_ff)
        else $error("overrun not cleared by read");

    // Transmit side
    chk_tx_write_data: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr_tx |=> tx_char_field_ff == ($past(wdata[7:0]) & $past(tx_mask)))
        else $error("transmit write lost");
    chk_tx_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !wr_tx && !seven_bit_select_ff |=> $stable(tx_char_field_ff))
        else $error("transmit buffer changed");
    chk_tx_read_data: assert property (@(posedge clk_sys) disable iff (!rst_n)
        rd && addr == `OFF_TX_DATA |=> rdata_ff == {8'h00, $past(tx_char_field_ff)})
        else $error("transmit read data wrong");
    chk_full_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        tx_full_ff && !lk.tx_take |=> tx_full_ff)
        else $error("transmit byte lost before take");
    chk_empty_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        tx_empty_flag_ff && !wr_tx && !wr_ifg |=> tx_empty_flag_ff)
        else $error("empty flag dropped");
    chk_seven_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr_tx && seven_bit_select_ff |=> !tx_char_field_ff[7])
        else $error("seven-bit write kept bit7");
    chk_eight_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr_tx && !seven_bit_select_ff |=> tx_char_field_ff[7] == $past(wdata[7]))
        else $error("eight-bit write lost bit7");
    chk_seven_select: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr_ctl |=> seven_bit_select_ff == $past(wdata[`BIT_SEVEN_BIT]))
        else $error("length select not taken");

    // Enables, vector and request
    chk_ie_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr_ie |=> irq_enable_ff == $past(wdata[1:0]))
        else $error("enable write lost");
    chk_ie_reserved: assert property (@(posedge clk_sys) disable iff (!rst_n)
        rd && addr == `OFF_IRQ_ENABLE |=> rdata_ff[15:2] == 14'h0000)
        else $error("enable reserved bits set");
    chk_flags_reserved: assert property (@(posedge clk_sys) disable iff (!rst_n)
        rd && addr == `OFF_IRQ_FLAGS |=> rdata_ff[15:2] == 14'h0000)
        else $error("flag reserved bits set");
    chk_vector_none: assert property (@(posedge clk_sys) disable iff (!rst_n)
        rd_iv && !(rx_done_flag_ff && irq_enable_ff[0]) && !(tx_empty_flag_ff && irq_enable_ff[1])
        |=> rdata_ff == 16'h0000)
        else $error("vector not idle");
    chk_irq_rx_source: assert property (@(posedge clk_sys) disable iff (!rst_n)
        rx_done_flag_ff && irq_enable_ff[0] |=> irq_ff)
        else $error("receive request missing");
    chk_irq_tx_source: assert property (@(posedge clk_sys) disable iff (!rst_n)
        tx_empty_flag_ff && irq_enable_ff[1] |=> irq_ff)
        else $error("transmit request missing");

    cov_receive: cover property (@(posedge clk_sys) disable iff (!rst_n) lk.rx_load ##[1:20] rd_rx);
    cov_overrun: cover property (@(posedge clk_sys) disable iff (!rst_n) overrun_flag_ff);
    cov_transmit: cover property (@(posedge clk_sys) disable iff (!rst_n) wr_tx ##[1:20] lk.tx_take);
    cov_seven_frame: cover property (@(posedge clk_sys) disable iff (!rst_n) seven_bit_select_ff && lk.rx_load);
    cov_vector_rx: cover property (@(posedge clk_sys) disable iff (!rst_n) rd_iv && rx_done_flag_ff && irq_enable_ff[0]);
endmodule

// File: verilog/spi_regs_consts.svh
// Register offsets, field positions, reset values and character width
`ifndef SPI_REGS_CONSTS_SVH
`define SPI_REGS_CONSTS_SVH
`define OFF_CONTROL 6'h00
`define OFF_STATUS 6'h08
`define OFF_RX_DATA 6'h0C
`define OFF_TX_DATA 6'h0E
`define OFF_IRQ_ENABLE 6'h2A
`define OFF_IRQ_FLAGS 6'h2C
`define OFF_IRQ_VECTOR 6'h2E
`define BIT_TX_EMPTY 1
`define BIT_RX_DONE 0
`define BIT_SEVEN_BIT 12
`define BIT_OVERRUN 5
`define RST_TX_DATA 8'h00
`define RST_IRQ_ENABLE 2'h0
`define RST_IRQ_FLAGS 2'h2
`define VEC_NONE 16'h0000
`define VEC_RX 16'h0002
`define VEC_TX 16'h0004
`define CHAR_BITS 8
`endif

// File: verilog/spi_regs_pkg.sv
// Types shared by the serial port register bank
package spi_regs_pkg;
    typedef enum logic [1:0] {
        SH_IDLE,
        SH_SHIFT,
        SH_DONE
    } shift_state_t;
endpackage
